// *** pkg/rwu_map.vh ***
/*
 * Constants of the reset and watchdog unit: register address, reset
 * value, field positions, vector and timing counts.
 * Assumes inclusion by bare name from the rtl files.
 */
`ifndef RWU_MAP_VH
`define RWU_MAP_VH

// Data-space address of the watchdog control/counter register
`define RWU_WDOG_ADDR       8'hD8
`define RWU_WDOG_RESET      8'hFE

// Register field positions
`define RWU_BIT_ACTIVATE    0
`define RWU_BIT_SWRESET     1
`define RWU_BIT_PERIOD_MSB  2
`define RWU_BIT_PERIOD_LSB  7

// Physical counter: bit 6 is the trigger bit, 7-bit timer when idle
`define RWU_CNT_W           7
`define RWU_CNT_TRIG        6

// Reset vector and stabilisation delay in internal clock cycles
`define RWU_RESET_VECTOR    12'hFFE
`define RWU_STAB_CYCLES     2048
`define RWU_STAB_W          11

// Watchdog tick: divide by 12, then by 256 (3072 cycles per decrement)
`define RWU_PRE_DIV         12
`define RWU_PRE_W           4
`define RWU_STAGE_DIV       256
`define RWU_STAGE_W         8

`endif

// *** rtl/rwu_stretch.v ***
/*
 * Reset stretcher: holds the internal reset while any source is active,
 * then for a fixed number of running-oscillator cycles.
 * Assumes all inputs are already synchronous to clk_i.
 */
`timescale 1ns/1ps
`include "rwu_map.vh"

module rwu_stretch (
	input  wire clk_i,
	input  wire resetn_i,
	input  wire assert_i,
	input  wire run_i,
	output reg  hold_o
);
	reg  [`RWU_STAB_W-1:0] cnt_reg;
	localparam [31:0]      LAST_FULL = `RWU_STAB_CYCLES - 1;
	wire [`RWU_STAB_W-1:0] last_c    = LAST_FULL[`RWU_STAB_W-1:0];

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt_reg <= {`RWU_STAB_W{1'b0}};
			hold_o  <= 1'b1;
		end else if (assert_i) begin
			cnt_reg <= {`RWU_STAB_W{1'b0}};
			hold_o  <= 1'b1;
		end else if (hold_o && run_i) begin
			// Count only while the oscillator runs
			if (cnt_reg == last_c) begin
				hold_o <= 1'b0;
			end
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule // rwu_stretch

// *** rtl/rwu_prescale.v ***
/*
 * Watchdog time base: divide by 12, then by 256, giving one tick pulse
 * every 3072 enabled cycles. Clear restarts both stages.
 * Assumes enable and clear come from logic on clk_i.
 */
`timescale 1ns/1ps
`include "rwu_map.vh"

module rwu_prescale (
	input  wire clk_i,
	input  wire resetn_i,
	input  wire clear_i,
	input  wire enable_i,
	output reg  tick_o
);
	reg  [`RWU_PRE_W-1:0]   pre_reg;
	reg  [`RWU_STAGE_W-1:0] stage_reg;
	localparam [31:0]       PRE_FULL   = `RWU_PRE_DIV - 1;
	localparam [31:0]       STAGE_FULL = `RWU_STAGE_DIV - 1;
	wire [`RWU_PRE_W-1:0]   pre_last   = PRE_FULL[`RWU_PRE_W-1:0];
	wire [`RWU_STAGE_W-1:0] stage_last = STAGE_FULL[`RWU_STAGE_W-1:0];
	wire                    pre_wrap   = (pre_reg == pre_last);

	always @(posedge clk_i) begin
		if (!resetn_i || clear_i) begin
			pre_reg   <= {`RWU_PRE_W{1'b0}};
			stage_reg <= {`RWU_STAGE_W{1'b0}};
			tick_o    <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (enable_i) begin
				pre_reg <= pre_wrap ? {`RWU_PRE_W{1'b0}} : pre_reg + 1'b1;
				if (pre_wrap) begin
					stage_reg <= stage_reg + 1'b1;
					tick_o    <= (stage_reg == stage_last);
				end
			end
		end
	end
endmodule // rwu_prescale

// *** rtl/rwu_top.v ***
/*
 * Reset and watchdog unit: merges pin, power-on and watchdog reset into
 * one stretched internal reset, holds the watchdog register and counter,
 * and steers run/wait/stop and the core start-up state.
 * Assumes clk_i is the internal oscillator clock, the data-space port is
 * driven by the core on clk_i, and pins/detectors arrive asynchronously.
 */
// Overview of operation
// - Internal reset comes from reset pin, power-on detector or watchdog timeout.
// - Reset is held as long as the reset pin stays low, any mode.
// - Internal reset stretches the pin reset, so short pulses reset fully.
// - Reset in run or wait halts code, pulls up all I/O, restarts oscillator.
// - Reset in stop starts oscillator, pulls up I/O, initialises after the delay.
// - Internal reset releases 2048 internal clock cycles after the source ends.
// - Power-on holds reset; the delay counts only once the oscillator runs.
// - Watchdog reset restarts like a pin reset, with the full delay.
// - Watchdog end of count activates reset, which also reinitialises the counter.
// - Any reset clears the stack and loads the program counter with 0FFEh.
// - Core starts in non-maskable mode until return-from-interrupt ends it.
// - At that return, a pending interrupt is serviced at once.
// - Watchdog resets when the downcounter passes from 40h to 3Fh; software must reload it.
// - Software option: disabled until activate bit set, then only reset disables.
// - Hardware option: always enabled; stop executes as wait, counting continues.
// - Stop only while watchdog disabled; leaving stop by interrupt resumes counting.
// - Register at 0D8h resets to 0FEh, longest period selected.
// - Software reset bit going to zero resets immediately; software writes it one.
// - Period bits are reversed: register bit 7 is counter LSB, bit 2 MSB.
// - Timeout is set by six upper bits; reset fires when counter bit 6 falls.
// - 64 periods from 3,072 to 196,608 oscillator cycles in 3,072 steps.
// - Hardware option reads activate bit as one; idle counter is a 7-bit timer.
`timescale 1ns/1ps
`include "rwu_map.vh"

module rwu_top (
	input  wire        clk_i,
	input  wire        resetn_i,
	input  wire        reset_pin_n_i,
	input  wire        por_i,
	input  wire        osc_ok_i,
	input  wire        hw_option_i,
	input  wire [7:0]  addr_i,
	input  wire [7:0]  wdata_i,
	input  wire        we_i,
	input  wire        re_i,
	input  wire        stop_instr_i,
	input  wire        wait_instr_i,
	input  wire        wake_irq_i,
	input  wire        return_from_interrupt_instr_i,
	input  wire        irq_pending_i,
	output reg  [7:0]  rdata_o,
	output reg         core_reset_o,
	output reg         io_pullup_o,
	output reg         stack_clear_o,
	output reg  [11:0] pc_vector_o,
	output reg         nmi_mode_o,
	output reg         irq_service_o,
	output reg         osc_run_o,
	output reg         wait_mode_o,
	output reg         stop_mode_o,
	output reg         wdog_active_o
);
	localparam [2:0] ST_RUN  = 3'b001;
	localparam [2:0] ST_WAIT = 3'b010;
	localparam [2:0] ST_STOP = 3'b100;

	// Register bits 7..2 hold counter bits 0..5
	function [5:0] rwu_rev6;
		input [5:0] v;
		integer i;
		begin
			for (i = 0; i < 6; i = i + 1) begin
				rwu_rev6[i] = v[5-i];
			end
		end
	endfunction

	// Register image to physical counter: SR on top, period bits reversed
	function [`RWU_CNT_W-1:0] rwu_to_cnt;
		input [7:0] r;
		begin
			rwu_to_cnt = {r[`RWU_BIT_SWRESET],
				rwu_rev6(r[`RWU_BIT_PERIOD_LSB:`RWU_BIT_PERIOD_MSB])};
		end
	endfunction

	// Physical counter and enable back to the register image
	function [7:0] rwu_to_reg;
		input [`RWU_CNT_W-1:0] c;
		input                  en;
		begin
			rwu_to_reg = {rwu_rev6(c[5:0]), c[`RWU_CNT_TRIG], en};
		end
	endfunction

	// Trigger bit falling between two counter values
	function rwu_trig_fall;
		input [`RWU_CNT_W-1:0] old_v;
		input [`RWU_CNT_W-1:0] new_v;
		begin
			rwu_trig_fall = old_v[`RWU_CNT_TRIG] && !new_v[`RWU_CNT_TRIG];
		end
	endfunction

	// Pin and detector synchronisers
	reg        pin_meta_reg;
	reg        pin_sync_reg;
	reg        por_meta_reg;
	reg        por_sync_reg;
	reg        osc_meta_reg;
	reg        osc_sync_reg;

	reg  [2:0] state_reg;
	reg  [2:0] state_next;
	reg        hw_opt_reg;
	reg        activate_reg;
	reg  [`RWU_CNT_W-1:0] cnt_reg;
	reg  [`RWU_CNT_W-1:0] cnt_next;
	reg        activate_next;
	reg        wd_fire_reg;

	// Sub-block results
	wire       hold;
	wire       tick;
	// Register port decode
	wire       reg_hit   = (addr_i == `RWU_WDOG_ADDR);
	wire       wr_hit    = we_i && reg_hit && !core_reset_o;
	wire       rd_hit    = re_i && reg_hit;
	wire       wd_en     = hw_opt_reg || activate_reg;
	wire       wd_armed  = wd_en || activate_next;
	// Reset sources and the register's reset image
	wire       src_reset = !pin_sync_reg || por_sync_reg || wd_fire_reg;
	// Any live source, or the stretched tail after it ends
	wire       reset_req = hold || src_reset;
	wire [7:0] rst_val   = `RWU_WDOG_RESET;
	wire [`RWU_CNT_W-1:0] cnt_rst = rwu_to_cnt(rst_val);

	// Decoded power mode
	wire       in_stop   = (state_reg == ST_STOP);
	wire       go_stop   = (state_next == ST_STOP);
	wire       go_wait   = (state_next == ST_WAIT);

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			por_meta_reg <= 1'b1;
			por_sync_reg <= 1'b1;
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
		end else begin
			pin_meta_reg <= reset_pin_n_i;
			pin_sync_reg <= pin_meta_reg;
			por_meta_reg <= por_i;
			por_sync_reg <= por_meta_reg;
			osc_meta_reg <= osc_ok_i;
			osc_sync_reg <= osc_meta_reg;
		end
	end

	rwu_stretch u_stretch (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.assert_i (src_reset),
		.run_i    (osc_sync_reg),
		.hold_o   (hold)
	);

	rwu_prescale u_prescale (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.clear_i  (core_reset_o),
		.enable_i (!in_stop),
		.tick_o   (tick)
	);

	// Counter and activate bit next values
	always @* begin
		cnt_next      = cnt_reg;
		activate_next = activate_reg;
		if (wr_hit) begin
			cnt_next = rwu_to_cnt(wdata_i);
			// Once set, only a reset clears it; the hardware option ignores it
			activate_next = activate_reg
				|| (wdata_i[`RWU_BIT_ACTIVATE] && !hw_opt_reg);
		end else if (tick) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always @(posedge clk_i) begin
		if (!resetn_i || core_reset_o) begin
			cnt_reg      <= cnt_rst;
			activate_reg <= 1'b0;
			wd_fire_reg  <= 1'b0;
		end else begin
			cnt_reg      <= cnt_next;
			activate_reg <= activate_next;
			// Trigger bit falling while enabled, by count or by write
			wd_fire_reg  <= wd_armed
				&& rwu_trig_fall(cnt_reg, cnt_next);
		end
	end

	// Option strap caught while the internal reset is held
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			hw_opt_reg <= 1'b0;
		end else if (core_reset_o) begin
			hw_opt_reg <= hw_option_i;
		end
	end

	// Read port, registered
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_o <= 8'h00;
		end else if (rd_hit) begin
			rdata_o <= rwu_to_reg(cnt_reg, wd_en);
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// Power mode sequencing
	always @* begin
		case (state_reg)
			ST_RUN: begin
				if (stop_instr_i) begin
					state_next = wd_en ? ST_WAIT : ST_STOP;
				end else if (wait_instr_i) begin
					state_next = ST_WAIT;
				end else begin
					state_next = ST_RUN;
				end
			end
			ST_WAIT: begin
				state_next = wake_irq_i ? ST_RUN : ST_WAIT;
			end
			ST_STOP: begin
				state_next = wake_irq_i ? ST_RUN : ST_STOP;
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (!resetn_i || core_reset_o) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Reset-facing outputs
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			core_reset_o  <= 1'b1;
			io_pullup_o   <= 1'b1;
			stack_clear_o <= 1'b1;
			pc_vector_o   <= `RWU_RESET_VECTOR;
		end else begin
			core_reset_o  <= reset_req;
			io_pullup_o   <= reset_req;
			stack_clear_o <= reset_req;
			pc_vector_o   <= `RWU_RESET_VECTOR;
		end
	end

	// Interrupt mode of the core after start-up
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			nmi_mode_o    <= 1'b1;
			irq_service_o <= 1'b0;
		end else begin
			irq_service_o <= 1'b0;
			if (core_reset_o) begin
				nmi_mode_o <= 1'b1;
			end else if (return_from_interrupt_instr_i && nmi_mode_o) begin
				nmi_mode_o    <= 1'b0;
				irq_service_o <= irq_pending_i;
			end
		end
	end

	// Power mode outputs
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			osc_run_o     <= 1'b1;
			wait_mode_o   <= 1'b0;
			stop_mode_o   <= 1'b0;
			wdog_active_o <= 1'b0;
		end else begin
			// Oscillator restarts on any reset, stops only in stop mode
			osc_run_o     <= core_reset_o || src_reset || !go_stop;
			wait_mode_o   <= !core_reset_o && go_wait;
			stop_mode_o   <= !core_reset_o && go_stop;
			wdog_active_o <= !core_reset_o && wd_armed;
		end
	end
endmodule // rwu_top

// *** sim/rwu_sva.sv ***
/* Checker of the reset and watchdog unit ports.
   Assumes it is bound to rwu_top. */
`timescale 1ns/1ps
module rwu_sva (
	input logic        clk_i,
	input logic        resetn_i,
	input logic        reset_pin_n_i,
	input logic        por_i,
	input logic        osc_ok_i,
	input logic        return_from_interrupt_instr_i,
	input logic        irq_pending_i,
	input logic        stop_instr_i,
	input logic        core_reset_o,
	input logic        io_pullup_o,
	input logic        stack_clear_o,
	input logic [11:0] pc_vector_o,
	input logic        nmi_mode_o,
	input logic        irq_service_o,
	input logic        wait_mode_o,
	input logic        stop_mode_o,
	input logic        wdog_active_o
);
	logic [11:0] quiet_reg;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// Held-reset cycles with every source quiet
	always @(posedge clk_i) begin
		if (!resetn_i || !core_reset_o || !reset_pin_n_i || por_i || !osc_ok_i)
			quiet_reg <= 12'h000;
		else
			quiet_reg <= quiet_reg + 12'h001;
	end
	a_pullup_follows: assert property (io_pullup_o == core_reset_o)
		else $error("pull-up differs from reset");
	a_stack_follows: assert property (stack_clear_o == core_reset_o)
		else $error("stack clear differs from reset");
	a_vector_fixed: assert property (pc_vector_o == 12'hFFE)
		else $error("reset vector wrong");
	a_pin_holds: assert property (!reset_pin_n_i [*4] |-> core_reset_o)
		else $error("pin low without reset");
	a_release_delay: assert property ($fell(core_reset_o) |->
		quiet_reg >= 12'h800 && quiet_reg <= 12'h80C) else $error("release delay wrong");
	a_nmi_at_start: assert property ($fell(core_reset_o) |-> nmi_mode_o)
		else $error("not in nmi mode after reset");
	a_return_from_interrupt_instr_ends: assert property (nmi_mode_o && return_from_interrupt_instr_i && !core_reset_o |=>
		!nmi_mode_o && irq_service_o == $past(irq_pending_i)) else $error("return_from_interrupt_instr wrong");
	a_service_cause: assert property (irq_service_o |-> $past(return_from_interrupt_instr_i))
		else $error("service without return_from_interrupt_instr");
	a_stop_when_off: assert property (stop_mode_o |-> !wdog_active_o)
		else $error("stop with watchdog on");
	a_stop_as_wait: assert property (stop_instr_i && wdog_active_o && !core_reset_o |=>
		wait_mode_o && !stop_mode_o) else $error("stop not taken as wait");
	cover property ($fell(core_reset_o));
	cover property (nmi_mode_o && return_from_interrupt_instr_i && irq_pending_i);
	cover property ($rose(stop_mode_o));
endmodule // rwu_sva

// *** sim/rwu_partner.sv ***
/* Model of the far side: supply, oscillator and reset pin.
   Assumes the bench calls its tasks; drives on falling edges. */
`timescale 1ns/1ps
module rwu_partner (
	input  logic clk_i,
	output logic reset_pin_n_o,
	output logic por_o,
	output logic osc_ok_o
);
	// Pin idles high through its pull-up
	initial begin
		reset_pin_n_o = 1'b1;
		por_o = 1'b1;
		osc_ok_o = 1'b0;
	end
	task automatic power_up(input int n);
		repeat (n) @(negedge clk_i);
		por_o = 1'b0;
		repeat (n) @(negedge clk_i);
		osc_ok_o = 1'b1; // Oscillator settles late
	endtask
	task automatic pin_pulse(input int n);
		@(negedge clk_i);
		reset_pin_n_o = 1'b0;
		repeat (n) @(negedge clk_i);
		reset_pin_n_o = 1'b1;
	endtask
endmodule // rwu_partner

// *** sim/tb_top.sv ***
/* Testbench of the reset and watchdog unit.
   Assumes rwu_top, rwu_partner and rwu_sva are compiled first. */
`timescale 1ns/1ps
module tb_top;
	logic        clk_i, resetn_i, hw_option_i, we_i, re_i, stop_instr_i, wait_instr_i;
	logic        wake_irq_i, return_from_interrupt_instr_i, irq_pending_i, reset_pin_n_i, por_i, osc_ok_i;
	logic        core_reset_o, io_pullup_o, stack_clear_o, nmi_mode_o, irq_service_o;
	logic        osc_run_o, wait_mode_o, stop_mode_o, wdog_active_o;
	logic [7:0]  addr_i, wdata_i, rdata_o, rv;
	logic [11:0] pc_vector_o;
	logic [15:0] since;
	int          failures, checks, n;
	rwu_top dut_u (.*);
	rwu_partner part_u (.clk_i(clk_i), .reset_pin_n_o(reset_pin_n_i), .por_o(por_i),
		.osc_ok_o(osc_ok_i));
	// Cycles since the internal reset last fell
	always @(posedge clk_i) since <= core_reset_o ? 16'h0000 : since + 16'h0001;
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		we_i = 1'b1;
		addr_i = a;
		wdata_i = d;
		@(negedge clk_i);
		we_i = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clk_i);
		re_i = 1'b1;
		addr_i = a;
		@(negedge clk_i);
		re_i = 1'b0;
		rv = rdata_o;
	endtask
	task automatic wait_lvl(input logic v);
		n = 0;
		while (core_reset_o !== v && n < 8000) begin
			@(negedge clk_i);
			n++;
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk_i);
		s = 1'b1;
		@(negedge clk_i);
		s = 1'b0;
	endtask
	task automatic s_start;
		part_u.power_up(8);
		wait_lvl(1'b0);
		chk(12'(n >= 2048 && n <= 2060), 12'h001);
		rd(8'hD8);
		chk(rv, 8'hFE);
		chk(pc_vector_o, 12'hFFE);
		chk(nmi_mode_o, 1'b1);
		rd(8'hD9);
		chk(rv, 8'h00);
		irq_pending_i = 1'b1;
		pulse(return_from_interrupt_instr_i);
		chk({nmi_mode_o, irq_service_o}, 2'b01);
		irq_pending_i = 1'b0;
	endtask
	task automatic s_stop;
		pulse(stop_instr_i);
		chk({stop_mode_o, osc_run_o}, 2'b10);
		pulse(wake_irq_i);
		chk({stop_mode_o, osc_run_o}, 2'b01);
	endtask
	task automatic s_watch;
		wr(8'hD8, 8'h03);
		chk(wdog_active_o, 1'b1);
		wr(8'hD8, 8'h02);
		rd(8'hD8);
		chk(rv, 8'h03);
		pulse(stop_instr_i);
		chk({wait_mode_o, stop_mode_o}, 2'b10);
		pulse(wake_irq_i);
		wait_lvl(1'b1);
		chk(12'(since >= 3072 && since <= 3082), 12'h001);
		wait_lvl(1'b0);
		chk(12'(n >= 2048), 12'h001);
		rd(8'hD8);
		chk({wdog_active_o, rv}, 9'h0FE);
	endtask
	task automatic s_swreset;
		wr(8'hD8, 8'hFD);
		wait_lvl(1'b1);
		chk(12'(n <= 4), 12'h001);
		wait_lvl(1'b0);
	endtask
	task automatic s_pin;
		part_u.pin_pulse(2);
		wait_lvl(1'b1);
		chk(12'(n <= 4), 12'h001);
		chk(io_pullup_o, 1'b1);
		wait_lvl(1'b0);
		chk(12'(n >= 2040 && n <= 2060), 12'h001);
	endtask
	task automatic s_timer;
		wr(8'hD8, 8'h82);
		repeat (3080) @(negedge clk_i);
		rd(8'hD8);
		chk(rv, 8'h02);
	endtask
	task automatic s_hw;
		hw_option_i = 1'b1;
		part_u.pin_pulse(6);
		wait_lvl(1'b0);
		chk(12'(n >= 2040 && n <= 2060), 12'h001);
		hw_option_i = 1'b0;
		rd(8'hD8);
		chk({wdog_active_o, rv}, 9'h1FF);
		wr(8'hD8, 8'hFE);
		rd(8'hD8);
		chk(rv, 8'hFF);
		pulse(stop_instr_i);
		chk({wait_mode_o, stop_mode_o, osc_run_o}, 3'b101);
		pulse(wake_irq_i);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		{resetn_i, hw_option_i, we_i, re_i, stop_instr_i, wait_instr_i} = 6'h00;
		{wake_irq_i, return_from_interrupt_instr_i, irq_pending_i, addr_i, wdata_i} = 19'h00000;
		failures = 0;
		checks = 0;
		repeat (2) @(negedge clk_i);
		resetn_i = 1'b1;
		s_start;
		s_stop;
		s_watch;
		s_swreset;
		s_pin;
		s_timer;
		s_hw;
		results;
	end
	initial begin
		#100000;
		failures++;
		results;
	end
endmodule // tb_top
bind rwu_top rwu_sva chk_u (.*);
